// [verilog/imc_pkg.sv]
package imc_pkg;
  // Register byte offsets
  localparam logic [7:0] IMC_OFS_CTRL = 8'h00;
  localparam logic [7:0] IMC_OFS_PARITY = 8'h04;
  localparam logic [7:0] IMC_OFS_STATUS = 8'h08;
  localparam logic [7:0] IMC_OFS_SYNC = 8'h0c;
  // Control fields
  localparam int IMC_CTRL_PAIR_BIT = 0;
  localparam int IMC_CTRL_OVR_BIT = 1;
  localparam int IMC_CTRL_RES_BIT = 2;
  localparam logic [2:0] IMC_CTRL_RESET = 3'h0;
  // Parity select codes
  localparam logic [15:0] IMC_PARITY_ODD = 16'h8000;
  localparam logic [15:0] IMC_PARITY_EVEN = 16'h80ff;
  localparam logic [15:0] IMC_PARITY_RESET = 16'h8000;
  // Configuration rate ceilings, MSPS
  localparam int IMC_MSPS_8CH_12B = 80;
  localparam int IMC_MSPS_8CH_10B = 100;
  localparam int IMC_MSPS_4CH_12B = 160;
  localparam int IMC_MSPS_4CH_10B = 200;
  localparam int IMC_LANES = 8;
  localparam int IMC_FIFO_DEPTH = 16;
  typedef enum logic [1:0] {
    IMC_CFG_8CH_12B,
    IMC_CFG_8CH_10B,
    IMC_CFG_4CH_12B,
    IMC_CFG_4CH_10B
  } imc_cfg_type;
endpackage

// [verilog/imc_fifo.sv]
`timescale 1ns/10ps
module imc_fifo
  import imc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Synchronised reset
  input wire logic [WIDTH-1:0] in_data, // Write word
  input wire logic in_valid, // Write offered
  output logic in_ready, // Room left
  output logic [WIDTH-1:0] out_data, // Head word
  output logic out_valid, // Head present
  input wire logic out_ready // Drain accepts
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin
    $error("imc_fifo: depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } imc_fifo_state_type;
  imc_fifo_state_type st;
  imc_fifo_state_type next_st;
  logic push;
  logic pop;
  assign in_ready = (st.wr - st.rd) != (AW+1)'(DEPTH);
  assign out_valid = st.wr != st.rd;
  assign out_data = mem[st.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

// [verilog/imc_top.sv]
`timescale 1ns/10ps
//
// Notes on behaviour
// (RULE1) Four configurations: 8ch 12/10 bit, 4ch interleaved 12/10 bit. Code fixes samples at 12 bit; IMC_CTRL_RES_BIT drives nothing.
// (RULE2) Interleaved pair shares one input; converters take odd/even edges.
// (RULE3) Input clock is twice each converter rate; offset one cycle.
// (RULE4) Interleaving divides input clock by two, two anti-phase clocks.
// (RULE5) Odd converters use one divided clock, even converters the other.
// (RULE6) Each converter of a pair drives its own adjacent lane.
// (RULE7) Receiver merges the two lanes of a pair alternately.
// (RULE8) After reset with interleave on, odd inputs are sampled.
// (RULE9) Override 0: parity code 8000h odd/straight, 80FFh even/swapped.
// (RULE10) Override 1: select pin chooses; low odd, high even.
// (RULE11) Non-interleaved straight maps k to k; swapped exchanges pairs.
// (RULE12) Undriven select pin reads high, giving even/swapped.
// (RULE13) Multi-device systems align sampling clocks via shared sync.
// (RULE14) Sync pulse restarts divide phase so odd converter samples first.
module imc_top
  import imc_pkg::*;
#(
  parameter int SAMPLE_W = 12
) (
  input wire logic clk, // Device input clock
  input wire logic rstn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic external_route_select_pin, // Route pin, pulled up
  input wire logic sync_pin, // Shared sync input
  input wire logic [SAMPLE_W-1:0] conv_data [IMC_LANES], // Converter k
  output logic [IMC_LANES-1:0] conv_sample_en, // Converter strobes
  output logic [IMC_LANES-1:0] analog_port_sel, // Analog port sel
  output logic [SAMPLE_W-1:0] serial_lane_k [IMC_LANES], // Lane words
  output logic serial_lane_valid, // Lane words valid
  input wire logic serial_lane_ready // Serializer ready
);
  if (SAMPLE_W != 12) begin
    $error("imc_top: sample width must be 12");
  end
  // ------------------------------------------------------------
  // Reset and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  typedef struct packed {
    logic [2:0] pin_sh;
    logic [2:0] sync_sh;
    logic pin_lvl;
    logic sync_lvl;
    logic [2:0] ctrl;
    logic [15:0] parity;
    logic phase;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [IMC_LANES-1:0] sample_en;
    logic [IMC_LANES-1:0] port_sel;
    logic swap;
  } imc_state_type;
  imc_state_type st;
  imc_state_type next_st;

  logic pair_sampling_enable;
  logic pin_select_override;
  logic even_sel;
  logic sync_rise;
  logic [SAMPLE_W*IMC_LANES-1:0] fifo_in;
  logic [SAMPLE_W*IMC_LANES-1:0] fifo_out;
  logic fifo_out_valid;
  logic wr_take;
  logic sync_wr;
  logic [SAMPLE_W-1:0] reg_lane [IMC_LANES];
  logic lane_valid;
  logic capture;

  assign pair_sampling_enable = st.ctrl[IMC_CTRL_PAIR_BIT];
  assign pin_select_override = st.ctrl[IMC_CTRL_OVR_BIT];
  // Pin level after filtering; reset value 1 mirrors the pull-up
  assign even_sel = pin_select_override ? st.pin_lvl // RULE10 RULE12
                  : (st.parity == IMC_PARITY_EVEN); // RULE9
  assign sync_rise = st.sync_lvl == 1'b0 && st.sync_sh[2] && st.sync_sh[1];
  // Writes land on the edge at which the master sees pready high
  assign wr_take = psel && penable && pwrite && st.pready;
  // Known before the phase update, so strobes and phase stay in step
  assign sync_wr = wr_take && paddr == IMC_OFS_SYNC && pwdata[0];

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pin_sh = {st.pin_sh[1:0], external_route_select_pin};
    next_st.sync_sh = {st.sync_sh[1:0], sync_pin};
    if (st.pin_sh[2] == st.pin_sh[1]) begin
      next_st.pin_lvl = st.pin_sh[2];
    end
    if (st.sync_sh[2] == st.sync_sh[1]) begin
      next_st.sync_lvl = st.sync_sh[2];
    end
    // Divide-by-two phase; sync restarts it so odd samples next
    if (!pair_sampling_enable || sync_rise || sync_wr) begin
      next_st.phase = 1'b0; // RULE14 RULE13
    end else begin
      next_st.phase = ~st.phase; // RULE4 RULE3
    end
    for (int k = 0; k < IMC_LANES; k++) begin
      if (pair_sampling_enable) begin
        // Odd converter (index 0,2..) on phase 0, even on phase 1
        next_st.sample_en[k] = (k % 2 == 0) ? ~next_st.phase
                                            : next_st.phase; // RULE2 RULE5
        // Both converters of a pair take the same analog port
        next_st.port_sel[k] = even_sel; // RULE2 RULE8
      end else begin
        next_st.sample_en[k] = 1'b1;
        next_st.port_sel[k] = 1'b0;
      end
    end
    next_st.swap = !pair_sampling_enable && even_sel; // RULE11
    // APB slave: one wait state, registered answer
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.prdata = '0;
      case (paddr)
        IMC_OFS_CTRL: begin
          next_st.prdata = {29'h0000_0000, st.ctrl};
        end
        IMC_OFS_PARITY: begin
          next_st.prdata = {16'h0000, st.parity};
        end
        IMC_OFS_STATUS: begin
          next_st.prdata = {28'h000_0000, st.phase, even_sel,
                            st.swap, fifo_out_valid};
        end
        IMC_OFS_SYNC: begin
          next_st.prdata = '0; // RULE14
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_take && paddr == IMC_OFS_CTRL) begin
      next_st.ctrl = pwdata[2:0]; // RULE1
    end
    if (wr_take && paddr == IMC_OFS_PARITY) begin
      next_st.parity = pwdata[15:0]; // RULE9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.pin_sh <= 3'b111;
      st.pin_lvl <= 1'b1; // RULE12
      st.ctrl <= IMC_CTRL_RESET;
      st.parity <= IMC_PARITY_RESET; // RULE8
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Lane routing and output buffer
  // ------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < IMC_LANES; k++) begin
      // Swapped: lane k takes its neighbour; interleaved: own converter
      if (st.swap) begin
        fifo_in[k*SAMPLE_W +: SAMPLE_W] = conv_data[k ^ 1]; // RULE11
      end else begin
        fifo_in[k*SAMPLE_W +: SAMPLE_W] = conv_data[k]; // RULE6
      end
    end
  end
  // Every converter word enters on each cycle that any strobe is high; a full FIFO
  // drops the whole group, so lanes never slip against each other
  assign capture = |st.sample_en;

  imc_fifo #(
    .WIDTH(SAMPLE_W*IMC_LANES),
    .DEPTH(IMC_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(fifo_in),
    .in_valid(capture),
    .in_ready(),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(!lane_valid || serial_lane_ready)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_valid <= 1'b0;
      for (int k = 0; k < IMC_LANES; k++) begin
        reg_lane[k] <= '0;
      end
    end else if (!lane_valid || serial_lane_ready) begin
      lane_valid <= fifo_out_valid;
      for (int k = 0; k < IMC_LANES; k++) begin
        reg_lane[k] <= fifo_out[k*SAMPLE_W +: SAMPLE_W];
      end
    end
  end

  assign serial_lane_k = reg_lane;
  assign serial_lane_valid = lane_valid;
  assign conv_sample_en = st.sample_en;
  assign analog_port_sel = st.port_sel;
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence odd_then_even;
    conv_sample_en[0] && !conv_sample_en[1] ##1
    conv_sample_en[1] && !conv_sample_en[0];
  endsequence
  // Pin restart seen, then one free-running cycle follows
  sequence sync_seen;
    pair_sampling_enable [*3] ##0 sync_rise ##1
    pair_sampling_enable && !sync_rise && !sync_wr;
  endsequence
  chk_phase_alternate: assert property ( // RULE4
    @(posedge clk) disable iff (!rst_n)
    pair_sampling_enable && $past(pair_sampling_enable, 2) &&
    !sync_rise && !sync_wr && conv_sample_en[0] |=> conv_sample_en[1])
    else $error("pair phase did not alternate");
  chk_pair_antiphase: assert property ( // RULE5
    @(posedge clk) disable iff (!rst_n)
    pair_sampling_enable && $past(pair_sampling_enable) |->
    conv_sample_en[0] != conv_sample_en[1] &&
    conv_sample_en[2] == conv_sample_en[0])
    else $error("pair clocks not anti-phase");
  chk_sync_odd_first: assert property ( // RULE14
    @(posedge clk) disable iff (!rst_n)
    pair_sampling_enable && (sync_rise || sync_wr) |=>
    conv_sample_en[0] && !conv_sample_en[1])
    else $error("odd converter not first after sync");
  chk_sync_sequence: assert property ( // RULE3
    @(posedge clk) disable iff (!rst_n)
    sync_seen |-> odd_then_even)
    else $error("sampling offset not one cycle");
  chk_same_port: assert property ( // RULE2
    @(posedge clk) disable iff (!rst_n)
    pair_sampling_enable && $past(pair_sampling_enable) |->
    analog_port_sel[0] == analog_port_sel[1])
    else $error("pair ports differ");
  chk_reg_route: assert property ( // RULE9
    @(posedge clk) disable iff (!rst_n)
    pair_sampling_enable && $past(pair_sampling_enable) &&
    !$past(pin_select_override) && $past(st.parity) == IMC_PARITY_ODD
    |-> analog_port_sel == '0)
    else $error("parity 8000h not odd");
  chk_pin_route: assert property ( // RULE10
    @(posedge clk) disable iff (!rst_n)
    pair_sampling_enable && $past(pair_sampling_enable) &&
    $past(pin_select_override) |->
    analog_port_sel[0] == $past(st.pin_lvl))
    else $error("pin route ignored");
  chk_swap_lane: assert property ( // RULE11
    @(posedge clk) disable iff (!rst_n)
    st.swap |-> fifo_in[SAMPLE_W-1:0] == conv_data[1])
    else $error("swap not applied");
  chk_no_swap_pair: assert property ( // RULE6
    @(posedge clk) disable iff (!rst_n)
    pair_sampling_enable && $past(pair_sampling_enable) |-> !st.swap)
    else $error("swap in interleave");
  chk_apb_ready: assert property ( // RULE1
    @(posedge clk) disable iff (!rst_n)
    psel && penable && !pready |=> pready)
    else $error("apb not answered");
endmodule

// [dv/imc_rx_model.sv]
`timescale 1ns/10ps
module imc_rx_model
  import imc_pkg::*;
(
  input wire logic clk, // Device clock
  input wire logic rst_n, // Reset, low
  input wire logic [11:0] lane_word [IMC_LANES], // Lane words
  input wire logic lane_valid, // Words offered
  input wire logic stall, // Hold off capture
  output logic lane_ready, // Capture accepts
  output logic [11:0] got [IMC_LANES] // Last group taken
);
  // Both lanes of a pair land together so the pair merges in order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_ready <= 1'b0;
    end else begin
      lane_ready <= !stall;
      if (lane_valid && lane_ready) begin
        got <= lane_word;
      end
    end
  end
endmodule

// [dv/imc_top_tb.sv]
`timescale 1ns/10ps
module imc_top_tb;
  import imc_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin = 1;
  logic sync = 0;
  logic stall = 0;
  logic [11:0] conv_data [IMC_LANES];
  logic [11:0] lane [IMC_LANES];
  logic [11:0] got [IMC_LANES];
  logic [7:0] en;
  logic [7:0] sel;
  logic lv;
  logic lr;
  logic [31:0] q;
  logic e;
  logic [7:0] v1;
  logic [7:0] v2;
  logic [11:0] hold;
  int failures = 0;
  int checked = 0;

  always #4 clk = ~clk;

  imc_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_route_select_pin(pin),
    .sync_pin(sync), .conv_data(conv_data), .conv_sample_en(en),
    .analog_port_sel(sel), .serial_lane_k(lane), .serial_lane_valid(lv),
    .serial_lane_ready(lr));

  imc_rx_model rx (.clk(clk), .rst_n(rstn), .lane_word(lane),
    .lane_valid(lv), .stall(stall), .lane_ready(lr), .got(got));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // No wait count assumed; the watchdog ends a hung access
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Long wait lets the FIFO flush and the pin synchroniser settle
  task automatic lanes_chk(input logic swap);
    repeat (24) @(posedge clk);
    for (int k = 0; k < IMC_LANES; k++) begin
      chk({20'h0_0000, got[k]}, {20'h0_0000, conv_data[swap ? k ^ 1 : k]});
    end
  endtask

  task automatic sync_en(input int gap, output logic [7:0] v);
    repeat (gap) @(posedge clk);
    sync <= 1'b1;
    repeat (3) @(posedge clk);
    sync <= 1'b0;
    repeat (10) @(posedge clk);
    v = en;
  endtask

  task automatic final_report;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    final_report;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    for (int k = 0; k < IMC_LANES; k++) begin
      conv_data[k] = {4'(k + 1), 8'h5a};
    end
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, IMC_OFS_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    apb(1'b0, IMC_OFS_PARITY, 32'h0000_0000);
    chk(q, {16'h0000, IMC_PARITY_RESET});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    lanes_chk(1'b0);
    chk({24'h00_0000, en}, 32'h0000_00ff);
    apb(1'b1, IMC_OFS_PARITY, 32'h0000_80ff);
    lanes_chk(1'b1);
    apb(1'b1, IMC_OFS_CTRL, 32'h0000_0002);
    lanes_chk(1'b1);
    pin <= 1'b0;
    lanes_chk(1'b0);
    pin <= 1'b1;
    apb(1'b1, IMC_OFS_PARITY, 32'h0000_8000);
    lanes_chk(1'b1);
    apb(1'b1, IMC_OFS_CTRL, 32'h0000_0000);
    lanes_chk(1'b0);
    apb(1'b1, IMC_OFS_CTRL, 32'h0000_0001);
    repeat (8) @(posedge clk);
    chk({24'h00_0000, sel}, 32'h0000_0000);
    v1 = en;
    @(posedge clk);
    chk({24'h00_0000, en}, {24'h00_0000, ~v1});
    chk({31'h0, v1 == 8'h55 || v1 == 8'haa}, 32'h0000_0001);
    chk({31'h0, v1[0] ^ v1[1]}, 32'h0000_0001);
    apb(1'b1, IMC_OFS_PARITY, 32'h0000_80ff);
    repeat (8) @(posedge clk);
    chk({24'h00_0000, sel}, 32'h0000_00ff);
    lanes_chk(1'b0);
    // Odd spacing: a free-running phase would give inverted strobes
    sync_en(2, v1);
    sync_en(4, v2);
    chk({24'h00_0000, v2}, {24'h00_0000, v1});
    apb(1'b1, IMC_OFS_SYNC, 32'h0000_0001);
    @(posedge clk);
    chk({24'h00_0000, en}, 32'h0000_0055);
    apb(1'b1, IMC_OFS_SYNC, 32'h0000_0001);
    @(posedge clk);
    chk({24'h00_0000, en}, 32'h0000_0055);
    apb(1'b1, IMC_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, IMC_OFS_PARITY, 32'h0000_8000);
    stall <= 1'b1;
    repeat (40) @(posedge clk);
    hold = lane[0];
    apb(1'b0, IMC_OFS_STATUS, 32'h0000_0000);
    chk({31'h0, q[0]}, 32'h0000_0001);
    chk({31'h0, lv}, 32'h0000_0001);
    chk({20'h0_0000, lane[0]}, {20'h0_0000, hold});
    // Fresh words must come through once the backlog drains
    for (int k = 0; k < IMC_LANES; k++) begin
      conv_data[k] <= {4'(k), 8'ha5};
    end
    stall <= 1'b0;
    lanes_chk(1'b0);
    final_report;
  end
endmodule
